/* logic/pcs_sequencer.sv */
// Program counter sequencer with upper-address latch and return stack
`timescale 1ns/1ps
`default_nettype none
module pcs_sequencer
	import pcs_pkg::*;
(
	// Clock and reset (any reset source, combined active low)
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Decoder request, one per executed instruction
	input  wire logic                  step,
	input  wire pcs_op_t               op,
	input  wire logic [BRANCH_W-1:0]   branch_addr,
	input  wire logic [LOW_W-1:0]      low_wr_data,
	// Upper-address latch write
	input  wire logic                  latch_wr,
	input  wire logic [LATCH_W-1:0]    latch_wr_data,
	// Sleep and wake
	input  wire logic                  wake_irq,
	input  wire logic                  global_interrupt_enable,
	// Visible state
	output logic      [PC_W-1:0]       fetch_addr,
	output logic      [LOW_W-1:0]      counter_low_byte,
	output logic      [LATCH_W-1:0]    upper_address_latch
);
	logic [PC_W-1:0]    pc_reg;
	logic [PC_W-1:0]    pc_next;
	logic [LATCH_W-1:0] latch_reg;
	logic               vec_pend_reg;
	logic               vec_pend_next;
	logic [PC_W-1:0]    pc_inc;
	logic [PC_W-1:0]    pc_abs;
	logic [PC_W-1:0]    pc_low;
	logic               do_vector;
	pcs_op_t            eff_op;

	pcs_stack_if sif ();

	// Return stack instance
	pcs_stack u_stack (
		.clk   (clk),
		.rst_n (rst_n),
		.sif   (sif.stk)
	);

	// Candidate next addresses
	assign pc_inc = PC_W'(pc_reg + 13'h0001);
	assign pc_abs = {latch_reg[PAGE_MSB:PAGE_LSB], branch_addr};
	assign pc_low = {latch_reg[HIGH_W-1:0], low_wr_data};
	// A pending wake vector overrides the first step after the wake, pushing that word's address
	assign do_vector = step && vec_pend_reg;
	assign eff_op = do_vector ? PCS_OP_IRQ : op;

	// Stack controls; vectoring pushes the address of the current word
	assign sif.push = step && ((eff_op == PCS_OP_CALL) || (eff_op == PCS_OP_IRQ));
	assign sif.pop = step && (eff_op == PCS_OP_RET);
	assign sif.push_data = (eff_op == PCS_OP_IRQ) ? pc_reg : pc_inc;

	// Next counter selection
	always_comb begin
		pc_next = pc_reg;
		if (step) begin
			case (eff_op)
				PCS_OP_NEXT:  pc_next = pc_inc;
				PCS_OP_JUMP:  pc_next = pc_abs;
				PCS_OP_CALL:  pc_next = pc_abs;
				PCS_OP_RET:   pc_next = sif.top_data;
				PCS_OP_IRQ:   pc_next = IRQ_VECTOR;
				PCS_OP_LOWWR: pc_next = pc_low;
				PCS_OP_HOLD:  pc_next = pc_reg;
				default:      pc_next = pc_inc;
			endcase
		end
	end

	// Wake vector pending: set on a wake with global_interrupt_enable high, cleared once taken
	assign vec_pend_next = (wake_irq && global_interrupt_enable) ? 1'b1 :
		(do_vector ? 1'b0 : vec_pend_reg);

	// Program counter, cleared by every reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= PC_RESET_VAL;
		end else begin
			pc_reg <= pc_next;
		end
	end

	// Latch written only by software; stack traffic never touches it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_reg <= LATCH_RESET;
		end else if (latch_wr) begin
			latch_reg <= latch_wr_data;
		end
	end

	// Pending vector flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vec_pend_reg <= 1'b0;
		end else begin
			vec_pend_reg <= vec_pend_next;
		end
	end

	// Outputs; only the low byte is visible to software
	assign fetch_addr = pc_reg;
	assign counter_low_byte = pc_reg[LOW_W-1:0];
	assign upper_address_latch = latch_reg;

	// Checks
	chk_inc_default: assert property (@(posedge clk) disable iff (!rst_n)
		step && !vec_pend_reg && op == PCS_OP_NEXT |=> pc_reg == $past(pc_reg) + 13'h0001)
		else $error("counter did not advance by one");
	chk_low_write: assert property (@(posedge clk) disable iff (!rst_n)
		step && !vec_pend_reg && op == PCS_OP_LOWWR
		|=> pc_reg == {$past(latch_reg[4:0]), $past(low_wr_data)})
		else $error("low byte write did not load upper bits from latch");
	chk_abs_branch: assert property (@(posedge clk) disable iff (!rst_n)
		step && !vec_pend_reg && (op == PCS_OP_JUMP || op == PCS_OP_CALL)
		|=> pc_reg == {$past(latch_reg[4:3]), $past(branch_addr)})
		else $error("absolute branch address wrong");
	chk_call_return: assert property (@(posedge clk) disable iff (!rst_n)
		step && !vec_pend_reg && op == PCS_OP_CALL
		##1 step && !vec_pend_reg && op == PCS_OP_RET
		|=> pc_reg == $past(pc_reg, 2) + 13'h0001)
		else $error("return did not restore address after call");
	chk_latch_stable: assert property (@(posedge clk) disable iff (!rst_n)
		!latch_wr |=> $stable(latch_reg))
		else $error("latch changed without a write");
	chk_hold_stable: assert property (@(posedge clk) disable iff (!rst_n)
		!step |=> $stable(pc_reg))
		else $error("counter moved without a step");
	chk_wake_vector: assert property (@(posedge clk) disable iff (!rst_n)
		vec_pend_reg && step |=> pc_reg == IRQ_VECTOR ##0 !vec_pend_reg || $past(wake_irq))
		else $error("wake vector not loaded after post-sleep word");
	chk_irq_push: assert property (@(posedge clk) disable iff (!rst_n)
		step && vec_pend_reg ##1 step && !vec_pend_reg && op == PCS_OP_RET
		|=> pc_reg == $past(pc_reg, 2))
		else $error("interrupt return address wrong");

	// Decoded requests seen by the checks; a pending vector masks the op
	logic               plain_step;
	logic               req_next;
	logic               req_jump;
	logic               req_call;
	logic               req_ret;
	logic               req_irq;
	logic               req_lowwr;
	logic               req_hold;
	logic               wake_take;
	assign plain_step = step && !vec_pend_reg;
	assign req_next   = plain_step && (op == PCS_OP_NEXT);
	assign req_jump   = plain_step && (op == PCS_OP_JUMP);
	assign req_call   = plain_step && (op == PCS_OP_CALL);
	assign req_ret    = plain_step && (op == PCS_OP_RET);
	assign req_irq    = plain_step && (op == PCS_OP_IRQ);
	assign req_lowwr  = plain_step && (op == PCS_OP_LOWWR);
	assign req_hold   = plain_step && (op == PCS_OP_HOLD);
	assign wake_take  = step && vec_pend_reg;

	// Stack traffic per request kind
	chk_next_no_stack: assert property (@(posedge clk) disable iff (!rst_n)
		req_next
		|-> !sif.push && !sif.pop)
		else $error("plain step touched the stack");
	chk_lowwr_no_stack: assert property (@(posedge clk) disable iff (!rst_n)
		req_lowwr
		|-> !sif.push && !sif.pop)
		else $error("low byte write touched the stack");
	chk_jump_no_stack: assert property (@(posedge clk) disable iff (!rst_n)
		req_jump
		|-> !sif.push && !sif.pop)
		else $error("jump touched the stack");
	chk_hold_no_stack: assert property (@(posedge clk) disable iff (!rst_n)
		req_hold
		|-> !sif.push && !sif.pop)
		else $error("hold touched the stack");
	chk_idle_no_stack: assert property (@(posedge clk) disable iff (!rst_n)
		!step
		|-> !sif.push && !sif.pop)
		else $error("stack moved without a step");
	chk_call_push: assert property (@(posedge clk) disable iff (!rst_n)
		req_call
		|-> sif.push && !sif.pop
			&& sif.push_data == pc_reg + 13'h0001)
		else $error("call did not push the next address");
	chk_irq_op_push: assert property (@(posedge clk) disable iff (!rst_n)
		req_irq
		|-> sif.push && !sif.pop
			&& sif.push_data == pc_reg)
		else $error("interrupt did not push the current address");
	chk_wake_push: assert property (@(posedge clk) disable iff (!rst_n)
		wake_take
		|-> sif.push && !sif.pop
			&& sif.push_data == pc_reg)
		else $error("wake vector did not push the current address");
	chk_ret_pop: assert property (@(posedge clk) disable iff (!rst_n)
		req_ret
		|-> sif.pop && !sif.push)
		else $error("return did not pop the stack");
	chk_call_top: assert property (@(posedge clk) disable iff (!rst_n)
		req_call
		|=> sif.top_data == $past(pc_reg) + 13'h0001)
		else $error("stack top wrong after call");
	chk_irq_top: assert property (@(posedge clk) disable iff (!rst_n)
		req_irq || wake_take
		|=> sif.top_data == $past(pc_reg))
		else $error("stack top wrong after vectoring");
	chk_top_untouched: assert property (@(posedge clk) disable iff (!rst_n)
		req_next || req_jump || req_lowwr || req_hold
		|=> $stable(sif.top_data))
		else $error("stack top changed without stack traffic");

	// Counter loading
	chk_ret_reload: assert property (@(posedge clk) disable iff (!rst_n)
		req_ret
		|=> pc_reg == $past(sif.top_data))
		else $error("return did not reload the whole counter");
	chk_irq_target: assert property (@(posedge clk) disable iff (!rst_n)
		req_irq
		|=> pc_reg == IRQ_VECTOR)
		else $error("interrupt did not load the vector");
	chk_hold_keep: assert property (@(posedge clk) disable iff (!rst_n)
		req_hold
		|=> $stable(pc_reg))
		else $error("hold moved the counter");
	chk_high_from_latch: assert property (@(posedge clk) disable iff (!rst_n)
		req_lowwr
		|=> pc_reg[12:8] == $past(latch_reg[4:0]))
		else $error("upper counter bits not taken from latch");
	chk_page_offset: assert property (@(posedge clk) disable iff (!rst_n)
		req_jump || req_call
		|=> pc_reg[10:0] == $past(branch_addr))
		else $error("branch offset not taken from instruction");
	chk_low_byte_load: assert property (@(posedge clk) disable iff (!rst_n)
		req_lowwr
		|=> counter_low_byte == $past(low_wr_data))
		else $error("written low byte not visible");
	chk_upper_kept: assert property (@(posedge clk) disable iff (!rst_n)
		req_next && pc_reg[7:0] != 8'hFF
		|=> pc_reg[12:8] == $past(pc_reg[12:8]))
		else $error("upper bits moved without a carry");

	// Latch ownership
	chk_latch_load: assert property (@(posedge clk) disable iff (!rst_n)
		latch_wr
		|=> latch_reg == $past(latch_wr_data))
		else $error("latch write not taken");
	chk_stack_latch: assert property (@(posedge clk) disable iff (!rst_n)
		(sif.push || sif.pop) && !latch_wr
		|=> $stable(latch_reg))
		else $error("stack traffic changed the latch");

	// Wake vector bookkeeping
	chk_pend_set: assert property (@(posedge clk) disable iff (!rst_n)
		wake_irq && global_interrupt_enable
		|=> vec_pend_reg)
		else $error("enabled wake did not arm the vector");
	chk_pend_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		wake_irq && !global_interrupt_enable && !vec_pend_reg
		|=> !vec_pend_reg)
		else $error("disabled wake armed the vector");
	chk_pend_keep: assert property (@(posedge clk) disable iff (!rst_n)
		vec_pend_reg && !step
		|=> vec_pend_reg)
		else $error("armed vector lost before a step");
	chk_pend_clear: assert property (@(posedge clk) disable iff (!rst_n)
		wake_take && !(wake_irq && global_interrupt_enable)
		|=> !vec_pend_reg)
		else $error("armed vector not cleared once taken");

	// Reset state, while reset is held and at release
	chk_reset_state: assert property (@(posedge clk)
		!rst_n && $past(!rst_n)
		|-> pc_reg == PC_RESET_VAL && latch_reg == LATCH_RESET
			&& !vec_pend_reg)
		else $error("state not cleared while reset held");
	chk_release_zero: assert property (@(posedge clk)
		$rose(rst_n) |-> pc_reg == PC_RESET_VAL)
		else $error("counter not zero at reset release");
endmodule : pcs_sequencer
`default_nettype wire

/* common/pcs_pkg.sv */
// Package with constants and types for the program counter and return stack
package pcs_pkg;
	localparam int PC_W          = 13;
	localparam int LOW_W         = 8;
	localparam int HIGH_W        = 5;
	localparam int LATCH_W       = 8;
	localparam int BRANCH_W      = 11;
	localparam int STACK_DEPTH   = 8;
	localparam int SP_W          = 3;
	localparam int PAGE_LSB      = 3;
	localparam int PAGE_MSB      = 4;
	localparam logic [12:0] PC_RESET_VAL  = 13'h0000;
	localparam logic [12:0] IRQ_VECTOR    = 13'h0004;
	localparam logic [7:0]  LATCH_RESET   = 8'h00;
	localparam logic [2:0]  SP_RESET      = 3'h0;

	// Sequencing operations requested by the decoder
	typedef enum logic [2:0] {
		PCS_OP_NEXT,
		PCS_OP_JUMP,
		PCS_OP_CALL,
		PCS_OP_RET,
		PCS_OP_IRQ,
		PCS_OP_LOWWR,
		PCS_OP_HOLD
	} pcs_op_t;
endpackage : pcs_pkg

/* common/pcs_stack_if.sv */
// Interface between the sequencer and the return-address stack
`timescale 1ns/1ps
`default_nettype none
interface pcs_stack_if;
	import pcs_pkg::*;
	logic              push;
	logic              pop;
	logic [PC_W-1:0]   push_data;
	logic [PC_W-1:0]   top_data;
	modport seq (output push, output pop, output push_data, input top_data);
	modport stk (input push, input pop, input push_data, output top_data);
endinterface : pcs_stack_if
`default_nettype wire

/* logic/pcs_stack_entry.sv */
// One 13-bit entry of the return-address stack
`timescale 1ns/1ps
`default_nettype none
module pcs_stack_entry
	import pcs_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	// Write port
	input  wire logic            wr_en,
	input  wire logic [PC_W-1:0] wr_data,
	// Stored value
	output logic      [PC_W-1:0] value
);
	logic [PC_W-1:0] value_reg;

	// Entry storage, cleared at reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value_reg <= PC_RESET_VAL;
		end else if (wr_en) begin
			value_reg <= wr_data;
		end
	end

	assign value = value_reg;
endmodule : pcs_stack_entry
`default_nettype wire

/* logic/pcs_stack.sv */
// Eight-level circular return-address stack
`timescale 1ns/1ps
`default_nettype none
module pcs_stack
	import pcs_pkg::*;
(
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Sequencer side
	pcs_stack_if.stk   sif
);
	logic [SP_W-1:0] sp_reg;
	logic [SP_W-1:0] sp_next;
	logic [SP_W-1:0] top_idx;
	logic [PC_W-1:0] entry_val [STACK_DEPTH];

	// Pointer wraps freely; no overflow or underflow flags
	assign sp_next = sif.push ? SP_W'(sp_reg + 3'h1) :
		sif.pop ? SP_W'(sp_reg - 3'h1) : sp_reg;
	assign top_idx = SP_W'(sp_reg - 3'h1);
	assign sif.top_data = entry_val[top_idx];

	// Hidden pointer, not visible to software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_reg <= SP_RESET;
		end else begin
			sp_reg <= sp_next;
		end
	end

	// Entries; a ninth push overwrites the first
	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_entry
		pcs_stack_entry u_entry (
			.clk     (clk),
			.rst_n   (rst_n),
			.wr_en   (sif.push && (sp_reg == SP_W'(i))),
			.wr_data (sif.push_data),
			.value   (entry_val[i])
		);
	end

	// Checks; pointer moves silently in both directions
	chk_ptr_push: assert property (@(posedge clk) disable iff (!rst_n)
		sif.push |=> sp_reg == $past(sp_reg) + 3'h1)
		else $error("stack pointer did not advance on push");
	chk_ptr_pop: assert property (@(posedge clk) disable iff (!rst_n)
		sif.pop && !sif.push |=> sp_reg == $past(sp_reg) - 3'h1)
		else $error("stack pointer did not retreat on pop");
	chk_wrap_first: assert property (@(posedge clk) disable iff (!rst_n)
		sif.push && sp_reg == 3'h0 |=> entry_val[0] == $past(sif.push_data))
		else $error("push at slot zero not stored there");
endmodule : pcs_stack
`default_nettype wire

/* sim/pcs_core_model.sv */
// Decoder and core model issuing sequencing requests
`timescale 1ns/1ps
`default_nettype none
module pcs_core_model
	import pcs_pkg::*;
(
	// Clock
	input  wire logic           clk,
	// Requests to the sequencer
	output logic                step,
	output pcs_op_t             op,
	output logic [BRANCH_W-1:0] branch_addr,
	output logic [LOW_W-1:0]    low_wr_data,
	output logic                latch_wr,
	output logic [LATCH_W-1:0]  latch_wr_data,
	output logic                wake_irq,
	output logic                global_interrupt_enable
);
	// Idle levels at time zero
	initial begin
		{step, latch_wr, wake_irq, global_interrupt_enable} = 4'h0;
		op = PCS_OP_HOLD;
		{branch_addr, low_wr_data, latch_wr_data} = 27'h0;
	end
	// One instruction; step stays up for back-to-back use
	task automatic issue(input pcs_op_t o, input logic [10:0] a, input logic [7:0] d);
		op = o;
		branch_addr = a;
		low_wr_data = d;
		step = 1'b1;
		@(negedge clk);
	endtask : issue
	// Page bits set before any cross-page branch
	task automatic set_latch(input logic [7:0] v);
		step = 1'b0;
		latch_wr = 1'b1;
		latch_wr_data = v;
		@(negedge clk);
		latch_wr = 1'b0;
		latch_wr_data = ~v;
	endtask : set_latch
	// Interrupt wake pulse from sleep
	task automatic wake(input logic g);
		step = 1'b0;
		wake_irq = 1'b1;
		global_interrupt_enable = g;
		@(negedge clk);
		wake_irq = 1'b0;
	endtask : wake
endmodule : pcs_core_model
`default_nettype wire

/* sim/program_counter_stack_test.sv */
// Self-checking bench for the program counter sequencer
`timescale 1ns/1ps
`default_nettype none
module program_counter_stack_test;
	import pcs_pkg::*;
	logic          clk = 1'b0;
	logic          rst_n;
	logic          step, latch_wr, wake_irq, global_interrupt_enable;
	pcs_op_t       op;
	logic [10:0]   branch_addr;
	logic [7:0]    low_wr_data, latch_wr_data, low_b, latch;
	logic [12:0]   pc, ret[9];
	int            n_fail = 0;
	int            n_tests = 0;
	// Clock
	always #5 clk = ~clk;
	pcs_core_model u_pcs_core_model (.clk(clk), .step(step), .op(op),
		.branch_addr(branch_addr), .low_wr_data(low_wr_data), .latch_wr(latch_wr),
		.latch_wr_data(latch_wr_data), .wake_irq(wake_irq),
		.global_interrupt_enable(global_interrupt_enable));
	pcs_sequencer u_pcs_sequencer (.clk(clk), .rst_n(rst_n), .step(step), .op(op),
		.branch_addr(branch_addr), .low_wr_data(low_wr_data), .latch_wr(latch_wr),
		.latch_wr_data(latch_wr_data), .wake_irq(wake_irq),
		.global_interrupt_enable(global_interrupt_enable),
		.fetch_addr(pc), .counter_low_byte(low_b), .upper_address_latch(latch));
	// Compare and count
	task automatic check(input string what, input logic [12:0] seen, input logic [12:0] want);
		n_tests++;
		if (seen !== want) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic pc_is(input logic [12:0] want);
		check("fetch_addr", pc, want);
		check("counter_low_byte", {5'h00, low_b}, {5'h00, want[7:0]});
	endtask : pc_is
	task automatic iss(input pcs_op_t o, input logic [10:0] a, input logic [12:0] want);
		u_pcs_core_model.issue(o, a, 8'h00);
		pc_is(want);
	endtask : iss
	// Reset, plain stepping, low-byte write and paging
	task automatic t_basic;
		pc_is(13'h0000);
		check("latch", {5'h00, latch}, 13'h0000);
		for (int i = 1; i <= 3; i++) iss(PCS_OP_NEXT, 11'h000, 13'(i));
		iss(PCS_OP_HOLD, 11'h000, 13'h0003);
		u_pcs_core_model.set_latch(8'hFB);
		u_pcs_core_model.issue(PCS_OP_LOWWR, 11'h000, 8'h34);
		pc_is(13'h1B34);
		for (int p = 0; p < 4; p++) begin
			u_pcs_core_model.set_latch({3'h0, 2'(p), 3'h5});
			iss(PCS_OP_JUMP, 11'h5A5, {2'(p), 11'h5A5});
		end
		$display("test basic done");
	endtask : t_basic
	// Calls, returns, wrap and interrupt vectoring
	task automatic t_stack;
		iss(PCS_OP_CALL, 11'h010, 13'h1810);
		iss(PCS_OP_RET, 11'h000, 13'h1DA6);
		check("latch", {5'h00, latch}, 13'h001D);
		for (int k = 0; k < 9; k++) begin
			ret[k] = pc + 13'h1;
			iss(PCS_OP_CALL, 11'(k * 16), {2'h3, 11'(k * 16)});
		end
		for (int k = 8; k > 0; k--) iss(PCS_OP_RET, 11'h000, ret[k]);
		iss(PCS_OP_RET, 11'h000, ret[8]);
		ret[0] = pc;
		iss(PCS_OP_IRQ, 11'h000, IRQ_VECTOR);
		iss(PCS_OP_RET, 11'h000, ret[0]);
		check("latch", {5'h00, latch}, 13'h001D);
		$display("test stack done");
	endtask : t_stack
	// Wake-up with interrupts off and on, then reset mid-run
	task automatic t_wake;
		ret[0] = pc;
		u_pcs_core_model.wake(1'b0);
		iss(PCS_OP_NEXT, 11'h000, ret[0] + 13'h1);
		u_pcs_core_model.wake(1'b1);
		@(negedge clk);
		pc_is(ret[0] + 13'h1);
		iss(PCS_OP_NEXT, 11'h000, IRQ_VECTOR);
		iss(PCS_OP_RET, 11'h000, ret[0] + 13'h1);
		u_pcs_core_model.wake(1'b0);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		pc_is(13'h0000);
		check("latch", {5'h00, latch}, 13'h0000);
		rst_n = 1'b1;
		@(negedge clk);
		pc_is(13'h0000);
		iss(PCS_OP_NEXT, 11'h000, 13'h0001);
		$display("test wake done");
	endtask : t_wake
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	// Main sequence
	initial begin
		rst_n = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_basic();
		t_stack();
		t_wake();
		finish_test();
	end
	// Watchdog
	initial begin
		#20000;
		n_fail++;
		finish_test();
	end
endmodule : program_counter_stack_test
`default_nettype wire
